// file: rtl/adv_verifier.sv
// Alarm delay selection and system-wide alarm verification sequencer
// Functional notes
// RQ1 - Supervisory latching is one panel-wide bit, not per point.
// RQ2 - Generic, trouble, power, reset, silence, drill, acknowledge points never latch.
// RQ3 - A fire-automatic input holds exactly one delay option code.
// RQ4 - Verification and day/night option refused for heat detector inputs.
// RQ5 - Delay option stored separately for each fire-automatic input.
// RQ6 - Effective delay derived from input option and day-mode selection.
// RQ7 - Verifying input activation withholds alarm, resets input, waits verification period.
// RQ8 - Retard-reset interval of fixed 20 seconds first.
// RQ9 - Then power reapplied; restart 3 s detector or 10 s zone module.
// RQ10 - Retard plus restart fixed, at most 30 s, no alarm from that input.
// RQ11 - Still active at restart end alarms, else confirm then standby.
// RQ12 - Re-alarm during confirmation declares alarm at once.
// RQ13 - Verification period programmable 90 to 180 s, default 90.
// RQ14 - At period end either alarm or restart of cycle; here standby.
// RQ15 - Verification only for fire-automatic smoke inputs.
// RQ16 - Verification enable kept per point.
// RQ17 - Any system alarm during confirmation alarms immediately.
// RQ18 - One verification timer for the whole system.
// RQ19 - Reset command issued to the verifying input point.
// RQ20 - Verification zone asserted throughout the verification period.
// RQ21 - Alarms from networked panels count during confirmation.
// RQ22 - Day-mode selects sequence or pre-signal, never both.
// RQ23 - Sequence and pre-signal delays apply only in day mode.
// RQ24 - Confirmation lasts period minus retard and restart, on 1 s tick.
`timescale 1ns/1ps
`include "adv_cfg.svh"

module adv_verifier
  import adv_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `ADV_TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire adv_bus_t    bus_req,
  output logic [31:0]      rdata,
  input  wire logic [15:0] point_active,
  input  wire logic        net_alarm,
  input  wire logic        panel_reset,
  output logic             fire_alarm,
  output logic             verify_zone,
  output logic             det_power_off,
  output logic             sline_reset_cmd,
  output logic [3:0]       sline_reset_addr,
  output logic [15:0]      seq_delay_req,
  output logic [15:0]      presig_delay_req,
  output logic [15:0]      point_status
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] eff_delay(input logic [1:0] opt, input logic day,
                                           input logic [1:0] dsel);
    logic [1:0] d;
    d = day ? dsel : `ADV_DSEL_NONE; // RQ23
    case (opt) // RQ6
      `ADV_OPT_VERIFY:   eff_delay = `ADV_EFF_VERIFY;
      `ADV_OPT_SEQPRE:   eff_delay = (d == `ADV_DSEL_SEQ) ? `ADV_EFF_SEQ :
                                     (d == `ADV_DSEL_PRE) ? `ADV_EFF_PRE : `ADV_EFF_NONE;
      `ADV_OPT_DAYNIGHT: eff_delay = (d == `ADV_DSEL_SEQ) ? `ADV_EFF_SEQ :
                                     (d == `ADV_DSEL_PRE) ? `ADV_EFF_PRE : `ADV_EFF_VERIFY;
      default:           eff_delay = `ADV_EFF_NONE;
    endcase
  endfunction

  function automatic logic is_alarm_type(input logic [3:0] pt);
    is_alarm_type = (pt == `ADV_PT_FIREAUTO) || (pt == `ADV_PT_MANUAL) ||
                    (pt == `ADV_PT_WATERFLOW) || (pt == `ADV_PT_GAS) ||
                    (pt == `ADV_PT_GENALARM);
  endfunction

  function automatic logic is_latching(input logic [3:0] pt, input logic sup_l);
    // Alarm classes and waterflow-delay latch, supervisory latches per the panel bit; every other class follows its input
    if (pt == `ADV_PT_SUPERV) begin
      is_latching = sup_l; // RQ1
    end else begin
      is_latching = is_alarm_type(pt) || (pt == `ADV_PT_WFDELAY); // RQ2
    end
  endfunction

  function automatic logic cfg_ok(input adv_pcfg_t c);
    logic verify_kind;
    verify_kind = (c.opt == `ADV_OPT_VERIFY) || (c.opt == `ADV_OPT_DAYNIGHT);
    cfg_ok = 1'b1;
    if (c.opt != `ADV_OPT_NONE && c.ptype != `ADV_PT_FIREAUTO) begin
      cfg_ok = 1'b0; // RQ15
    end
    if (verify_kind && c.heat) begin
      cfg_ok = 1'b0; // RQ4
    end
  endfunction

  // ----------------------------------------------------------------
  // Point decode
  // ----------------------------------------------------------------
  adv_state_t s;
  adv_state_t n;
  logic [15:0] imm_alarm;
  logic [15:0] verify_rise;
  logic [15:0] alarm_act;
  logic [15:0] seq_v;
  logic [15:0] pre_v;
  logic [15:0] cfg_ok_v;

  always_comb begin
    for (int i = 0; i < `ADV_NPTS; i++) begin
      logic [1:0] e;
      logic       fa;
      e  = eff_delay(s.pcfg[i].opt, s.day_mode, s.day_sel);
      fa = (s.pcfg[i].ptype == `ADV_PT_FIREAUTO);
      alarm_act[i]   = point_active[i] && is_alarm_type(s.pcfg[i].ptype);
      imm_alarm[i]   = alarm_act[i] && (!fa || e == `ADV_EFF_NONE);
      verify_rise[i] = point_active[i] && !s.act_prev[i] && fa && e == `ADV_EFF_VERIFY; // RQ16
      seq_v[i]       = point_active[i] && fa && e == `ADV_EFF_SEQ;
      pre_v[i]       = point_active[i] && fa && e == `ADV_EFF_PRE;
      cfg_ok_v[i]    = cfg_ok(s.pcfg[i]);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       wr_refuse;
    logic       clr_refuse;
    logic       found;
    logic [3:0] hit;
    logic [7:0] el_inc;
    adv_pcfg_t  wc;
    n          = s;
    wr_refuse  = 1'b0;
    clr_refuse = 1'b0;
    found      = 1'b0;
    hit        = 4'h0;
    el_inc     = 8'(s.elapsed + 8'h01);
    wc         = adv_pcfg_t'(bus_req.wdata[7:0]);
    n.tick     = 1'b0;
    n.rst_cmd  = 1'b0;
    n.rdata    = 32'h0000_0000;

    // One-second enable shared by the single verification timer
    if (s.tick_cnt == 25'(TICK_CYCLES - 1)) begin
      n.tick_cnt = 25'h000_0000;
      n.tick     = 1'b1;
    end else begin
      n.tick_cnt = 25'(s.tick_cnt + 25'h000_0001);
    end

    // Register writes
    if (bus_req.wr) begin
      if (bus_req.addr[7:6] == `ADV_PCFG_SEL && bus_req.addr[1:0] == 2'h0) begin
        // Illegal option is stored as no delay so no stale feature remains
        if (cfg_ok(wc)) begin
          n.pcfg[bus_req.addr[5:2]] = wc; // RQ5 RQ3
        end else begin
          n.pcfg[bus_req.addr[5:2]]     = wc;
          n.pcfg[bus_req.addr[5:2]].opt = `ADV_OPT_NONE; // RQ4 RQ15
          wr_refuse                     = 1'b1;
        end
      end else begin
        case (bus_req.addr)
          `ADV_OFF_CTRL: begin
            n.day_mode  = bus_req.wdata[`ADV_CTRL_DAY];
            n.sup_latch = bus_req.wdata[`ADV_CTRL_SUPL]; // RQ1
            if (bus_req.wdata[`ADV_CTRL_DSEL +: 2] == `ADV_DSEL_BAD) begin
              wr_refuse = 1'b1; // RQ22
            end else begin
              n.day_sel = bus_req.wdata[`ADV_CTRL_DSEL +: 2];
            end
          end
          `ADV_OFF_PERIOD: begin
            if (bus_req.wdata[7:0] >= `ADV_PERIOD_MIN && bus_req.wdata[7:0] <= `ADV_PERIOD_MAX
                && bus_req.wdata[31:8] == 24'h00_0000) begin
              n.period = bus_req.wdata[7:0]; // RQ13
            end else begin
              wr_refuse = 1'b1;
            end
          end
          `ADV_OFF_STATUS: clr_refuse = bus_req.wdata[`ADV_STAT_REFUSED];
          `ADV_OFF_VCOUNT: n.vcount = 16'h0000;
          default: ;
        endcase
      end
    end
    // A refusal in the clearing cycle stays visible
    n.refused = (s.refused && !clr_refuse) || wr_refuse;

    // Register reads, answered in the following cycle
    if (bus_req.rd) begin
      if (bus_req.addr[7:6] == `ADV_PCFG_SEL && bus_req.addr[1:0] == 2'h0) begin
        n.rdata = {24'h00_0000, s.pcfg[bus_req.addr[5:2]]};
      end else begin
        case (bus_req.addr)
          `ADV_OFF_CTRL:   n.rdata = {28'h000_0000, s.sup_latch, s.day_sel, s.day_mode};
          `ADV_OFF_PERIOD: n.rdata = {24'h00_0000, s.period};
          `ADV_OFF_STATUS: n.rdata = {12'h000, s.vidx, s.elapsed, 1'b0, 3'(s.fsm),
                                      1'b0, s.refused, s.zone, s.alarm};
          `ADV_OFF_PSTAT:  n.rdata = {16'h0000, s.pstat};
          `ADV_OFF_VCOUNT: n.rdata = {16'h0000, s.vcount};
          default:         n.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Point state and latching
    n.act_prev = point_active;
    for (int i = 0; i < `ADV_NPTS; i++) begin
      if (point_active[i] && is_latching(s.pcfg[i].ptype, s.sup_latch)) begin
        n.latch[i] = 1'b1; // RQ1 RQ2
      end else if (panel_reset) begin
        n.latch[i] = 1'b0;
      end
    end
    n.pstat   = point_active | n.latch;
    n.seq_req = seq_v; // RQ23
    n.pre_req = pre_v;

    // Lowest-numbered verifying input wins when several rise together
    for (int i = `ADV_NPTS - 1; i >= 0; i--) begin
      if (verify_rise[i]) begin
        found = 1'b1;
        hit   = 4'(i);
      end
    end

    // Shared verification timer
    if (s.tick && s.fsm inside {st_retard, st_restart, st_confirm}) begin
      n.elapsed = el_inc; // RQ18 RQ24
    end

    case (s.fsm)
      st_idle: begin
        if (found) begin
          n.fsm      = st_retard; // RQ7
          n.elapsed  = 8'h00;
          n.vidx     = hit;
          n.rst_cmd  = 1'b1; // RQ19
          n.rst_addr = hit;
          n.vcount   = 16'(s.vcount + 16'h0001);
        end
      end
      st_retard: begin
        // Detector held unpowered; its alarm is deliberately ignored
        if (s.tick && el_inc >= 8'(`ADV_RETARD_T)) begin
          n.fsm       = st_restart; // RQ8
          n.phase_end = s.pcfg[s.vidx].czm ? 8'(`ADV_RETARD_T + `ADV_CZM_T)
                                           : 8'(`ADV_RETARD_T + `ADV_DET_T); // RQ9 RQ10
        end
      end
      st_restart: begin
        if (s.tick && el_inc >= s.phase_end) begin
          n.fsm = point_active[s.vidx] ? st_alarm : st_confirm; // RQ11
        end
      end
      st_confirm: begin
        if ((|alarm_act) || net_alarm) begin
          n.fsm = st_alarm; // RQ12 RQ17 RQ21
        end else if (s.tick && el_inc >= s.period) begin
          n.fsm = st_idle; // RQ14 RQ24
        end
      end
      st_alarm: begin
        if (panel_reset) begin
          n.fsm = st_idle;
        end
      end
      default: n.fsm = st_idle;
    endcase
    if (panel_reset && n.fsm != st_alarm) begin
      n.fsm = st_idle;
    end

    n.zone    = n.fsm inside {st_retard, st_restart, st_confirm}; // RQ20
    n.pwr_off = (n.fsm == st_retard); // RQ9
    // A live alarm input wins over the panel reset
    if ((|imm_alarm) || n.fsm == st_alarm) begin
      n.alarm = 1'b1;
    end else if (panel_reset) begin
      n.alarm = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s        <= '0;
      s.period <= `ADV_PERIOD_RST; // RQ13
      s.fsm    <= st_idle;
    end else begin
      s <= n;
    end
  end

  assign rdata            = s.rdata;
  assign fire_alarm       = s.alarm;
  assign verify_zone      = s.zone;
  assign det_power_off    = s.pwr_off;
  assign sline_reset_cmd  = s.rst_cmd;
  assign sline_reset_addr = s.rst_addr;
  assign seq_delay_req    = s.seq_req;
  assign presig_delay_req = s.pre_req;
  assign point_status     = s.pstat;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int RETARD_MAX = `ADV_RETARD_T;
  localparam int RRR_MAX    = `ADV_RRR_MAX_T;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_reset_cmd_start: assert property ( // RQ19
    $rose(verify_zone) |-> sline_reset_cmd && sline_reset_addr == s.vidx)
    else $error("verification started without input reset");
  a_retard_bound: assert property ( // RQ8
    s.fsm == st_retard |-> s.elapsed < RETARD_MAX && det_power_off)
    else $error("retard interval overran");
  a_rrr_bound: assert property ( // RQ10
    s.fsm == st_restart |-> s.elapsed < RRR_MAX && s.elapsed >= RETARD_MAX)
    else $error("retard reset restart out of bounds");
  a_period_range: assert property ( // RQ13
    s.period >= `ADV_PERIOD_MIN && s.period <= `ADV_PERIOD_MAX)
    else $error("verification period out of range");
  a_confirm_alarm: assert property ( // RQ17
    s.fsm == st_confirm && ((|alarm_act) || net_alarm) && !panel_reset
      |=> fire_alarm && verify_zone == 1'b0)
    else $error("alarm during confirmation not declared");
  a_confirm_end: assert property ( // RQ24
    s.fsm == st_confirm |-> s.elapsed < s.period)
    else $error("confirmation outlived the period");
  a_cfg_legal: assert property ( // RQ4
    &cfg_ok_v)
    else $error("illegal delay option stored");
  a_day_sel_legal: assert property ( // RQ22
    s.day_sel != 2'h3)
    else $error("sequence and pre-signal both selected");
  a_night_no_delay: assert property ( // RQ23
    !s.day_mode |=> seq_delay_req == 16'h0000 && presig_delay_req == 16'h0000)
    else $error("day delay requested at night");
  a_zone_tracks: assert property ( // RQ20
    $rose(s.fsm == st_retard) |-> verify_zone ##1 verify_zone)
    else $error("verification zone not asserted");
  a_rrr_no_alarm: assert property ( // RQ10
    (s.fsm == st_retard || s.fsm == st_restart) && !fire_alarm && !(|imm_alarm)
      |=> !fire_alarm || s.fsm == st_alarm)
    else $error("alarm produced during retard reset restart");
  a_confirm_source: assert property ( // RQ11
    s.fsm == st_confirm |-> $past(s.fsm) == st_restart || $past(s.fsm) == st_confirm)
    else $error("confirmation entered without restart");
  a_imm_alarm_out: assert property ( // RQ6
    (|imm_alarm) |=> fire_alarm)
    else $error("undelayed alarm not declared");
  a_reset_pulse: assert property ( // RQ19
    sline_reset_cmd && verify_zone |=> !sline_reset_cmd)
    else $error("input reset command longer than one cycle");
  a_power_at_start: assert property ( // RQ7
    sline_reset_cmd && verify_zone |-> det_power_off)
    else $error("detector power kept on at verification start");
  a_vidx_hold: assert property ( // RQ18
    s.fsm != st_idle && $past(s.fsm) != st_idle |-> $stable(s.vidx))
    else $error("verifying input changed while timer busy");
  a_restart_span: assert property ( // RQ9
    s.fsm == st_restart |-> s.phase_end == 8'h1E || s.phase_end == 8'h17)
    else $error("restart end outside detector or zone module time");

  c_confirm_entry: cover property (s.fsm == st_restart ##1 s.fsm == st_confirm);
  c_confirm_alarm: cover property (s.fsm == st_confirm ##1 s.fsm == st_alarm);
  c_confirm_idle:  cover property (s.fsm == st_confirm ##1 s.fsm == st_idle);
  c_imm_alarm:     cover property (|imm_alarm ##1 fire_alarm);
  c_restart_alarm: cover property (s.fsm == st_restart ##1 s.fsm == st_alarm);

endmodule // adv_verifier

// file: rtl/adv_cfg.svh
// Offsets, field positions, reset values, codes and timing counts of the alarm delay verifier
`ifndef ADV_CFG_SVH
`define ADV_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define ADV_NPTS          16
`define ADV_AW            8
`define ADV_DW            32

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADV_OFF_CTRL      8'h00
`define ADV_OFF_PERIOD    8'h04
`define ADV_OFF_STATUS    8'h08
`define ADV_OFF_PSTAT     8'h0C
`define ADV_OFF_VCOUNT    8'h10
`define ADV_PCFG_SEL      2'h1

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ADV_CTRL_DAY      0
`define ADV_CTRL_DSEL     1
`define ADV_CTRL_SUPL     3
`define ADV_STAT_REFUSED  2
`define ADV_PERIOD_RST    8'h5A
`define ADV_PERIOD_MIN    8'h5A
`define ADV_PERIOD_MAX    8'hB4

// ----------------------------------------------------------------
// Codes: day-mode selection, per-input option, effective delay
// ----------------------------------------------------------------
`define ADV_DSEL_NONE     2'h0
`define ADV_DSEL_SEQ      2'h1
`define ADV_DSEL_PRE      2'h2
`define ADV_DSEL_BAD      2'h3
`define ADV_OPT_NONE      2'h0
`define ADV_OPT_VERIFY    2'h1
`define ADV_OPT_SEQPRE    2'h2
`define ADV_OPT_DAYNIGHT  2'h3
`define ADV_EFF_NONE      2'h0
`define ADV_EFF_VERIFY    2'h1
`define ADV_EFF_SEQ       2'h2
`define ADV_EFF_PRE       2'h3

// ----------------------------------------------------------------
// Point types
// ----------------------------------------------------------------
`define ADV_PT_FIREAUTO   4'h0
`define ADV_PT_MANUAL     4'h1
`define ADV_PT_WATERFLOW  4'h2
`define ADV_PT_WFDELAY    4'h3
`define ADV_PT_GAS        4'h4
`define ADV_PT_SUPERV     4'h5
`define ADV_PT_GENALARM   4'hE

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADV_CLK_HZ        20000000
`define ADV_TICK_S        1
`define ADV_TICK_CYCLES   (`ADV_CLK_HZ * `ADV_TICK_S)
`define ADV_RETARD_S      20
`define ADV_DET_RESTART_S 3
`define ADV_CZM_RESTART_S 10
`define ADV_RRR_MAX_S     30
`define ADV_RETARD_T      (`ADV_RETARD_S / `ADV_TICK_S)
`define ADV_DET_T         (`ADV_DET_RESTART_S / `ADV_TICK_S)
`define ADV_CZM_T         (`ADV_CZM_RESTART_S / `ADV_TICK_S)
`define ADV_RRR_MAX_T     (`ADV_RRR_MAX_S / `ADV_TICK_S)

`endif

// file: rtl/adv_pkg.sv
// Types of the alarm delay verifier
package adv_pkg;
  `include "adv_cfg.svh"

  typedef enum logic [2:0] {
    st_idle, st_retard, st_restart, st_confirm, st_alarm
  } adv_fsm_t;

  typedef struct packed {
    logic       czm;
    logic       heat;
    logic [3:0] ptype;
    logic [1:0] opt;
  } adv_pcfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } adv_bus_t;

  typedef struct packed {
    logic                   day_mode;
    logic [1:0]             day_sel;
    logic                   sup_latch;
    logic [7:0]             period;
    adv_pcfg_t [15:0]       pcfg;
    adv_fsm_t               fsm;
    logic [7:0]             elapsed;
    logic [7:0]             phase_end;
    logic [3:0]             vidx;
    logic [24:0]            tick_cnt;
    logic                   tick;
    logic [15:0]            act_prev;
    logic [15:0]            latch;
    logic                   alarm;
    logic                   zone;
    logic                   pwr_off;
    logic                   rst_cmd;
    logic [3:0]             rst_addr;
    logic                   refused;
    logic [15:0]            vcount;
    logic [15:0]            seq_req;
    logic [15:0]            pre_req;
    logic [15:0]            pstat;
    logic [31:0]            rdata;
  } adv_state_t;
endpackage

// file: tb/adv_sline_model.sv
// Model of the detectors and input modules on the signaling line circuit
`timescale 1ns/1ps
module adv_sline_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [15:0] smoke,
  input  wire logic [3:0]  wake_cyc,
  input  wire logic        sline_reset_cmd,
  input  wire logic [3:0]  sline_reset_addr,
  input  wire logic        det_power_off,
  output logic [15:0]      point_active
);
  // A reset point stays quiet until power is back and its restart has run out
  logic [15:0] held_r;
  logic [3:0]  wake_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      held_r <= '0;
      wake_r <= '0;
    end else begin
      if (det_power_off) begin
        wake_r <= wake_cyc;
      end else if (wake_r != 4'h0) begin
        wake_r <= wake_r - 4'h1;
      end else begin
        held_r <= '0;
      end
      if (sline_reset_cmd) begin
        held_r[sline_reset_addr] <= 1'b1;
      end
    end
  end

  assign point_active = smoke & ~held_r;
endmodule // adv_sline_model

// file: tb/adv_verifier_test.sv
// Self-checking bench of the alarm delay verifier
`timescale 1ns/1ps
module adv_verifier_test;
  import adv_pkg::*;
  localparam int TK = 4;
  // Config written to point 3 and what must read back
  localparam logic [7:0] CW [6] = '{8'h41, 8'h43, 8'h42, 8'h05, 8'h0B, 8'h01};
  localparam logic [7:0] CR [6] = '{8'h40, 8'h40, 8'h42, 8'h04, 8'h08, 8'h01};
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  adv_bus_t    bus_req = '0;
  logic        net_alarm = 1'b0;
  logic        panel_reset = 1'b0;
  logic [15:0] smoke = '0;
  logic [3:0]  wake = 4'h1;
  logic [31:0] rdata;
  logic [15:0] point_active;
  logic [15:0] seq_req;
  logic [15:0] pre_req;
  logic [15:0] pstat;
  logic        alarm;
  logic        zone;
  logic        pwr_off;
  logic        rcmd;
  logic [3:0]  raddr;
  logic [3:0]  obs;
  logic        rd_d = 1'b0;
  logic [31:0] rq[$];
  logic [1:0]  eq[$];
  int          failures = 0;
  int          n_compared = 0;
  int          seed = 32'hd0a9_3684;

  assign obs = {alarm, zone, pwr_off, rcmd};
  always #25 clock = ~clock;

  adv_verifier #(.TICK_CYCLES(TK)) i_dut (
    .clock(clock), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .point_active(point_active), .net_alarm(net_alarm), .panel_reset(panel_reset),
    .fire_alarm(alarm), .verify_zone(zone), .det_power_off(pwr_off),
    .sline_reset_cmd(rcmd), .sline_reset_addr(raddr), .seq_delay_req(seq_req),
    .presig_delay_req(pre_req), .point_status(pstat));
  adv_sline_model i_det (
    .clock(clock), .rstn(rstn), .smoke(smoke), .wake_cyc(wake),
    .sline_reset_cmd(rcmd), .sline_reset_addr(raddr), .det_power_off(pwr_off),
    .point_active(point_active));

  // ------
  // Checks
  // ------
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(string nm, int lo, int hi, int g);
    n_compared++;
    if (g < lo || g > hi) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Read data and first delay response are matched against the oldest note
  always @(posedge clock) begin
    if (rd_d) begin
      chk("rdata", rq.pop_front(), rdata);
    end
    rd_d <= bus_req.rd;
    if (eq.size() > 0 && (rcmd || alarm || seq_req != 0 || pre_req != 0)) begin
      chk("delay", eq.pop_front(),
          rcmd ? 2'h1 : seq_req != 0 ? 2'h2 : pre_req != 0 ? 2'h3 : 2'h0);
    end
  end

  // ------
  // Drivers
  // ------
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    if (!w) begin
      rq.push_back(d);
    end
    bus_req <= '{a, w ? d : 32'h0, w, !w};
    @(posedge clock);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wait_obs(int b, logic v, int n, output int c);
    c = 0;
    while (obs[b] !== v && c < n) begin
      @(posedge clock);
      c++;
    end
    if (c >= n) begin
      failures++;
      $display("mismatch wait %0d expected %b seen %b", b, v, obs[b]);
      test_done();
    end
  endtask

  task automatic fire(int i, logic [1:0] e);
    int c;
    eq.push_back(e);
    smoke[i] <= 1'b1;
    for (c = 0; eq.size() > 0; c++) begin
      if (c == 20) begin
        failures++;
        $display("mismatch delay expected %0d seen none", e);
        test_done();
      end
      @(posedge clock);
    end
  endtask

  // Removes every cause, lets verification end, then resets the panel
  task automatic clean();
    int c;
    smoke <= '0;
    net_alarm <= 1'b0;
    wait_obs(2, 1'b0, 1000, c);
    panel_reset <= 1'b1;
    @(posedge clock);
    panel_reset <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  function automatic logic [1:0] eff(int o, int d, int s);
    int m;
    m = d ? s : 0;
    if (o == 0 || (o == 2 && m == 0)) return 2'h0;
    if (o == 1 || m == 0) return 2'h1;
    return m == 1 ? 2'h2 : 2'h3;
  endfunction

  // ------
  // Scenarios
  // ------
  initial begin
    int c;
    int p;
    int idx;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    bus(0, 8'h00, 32'h0);
    bus(0, 8'h04, 32'h5A);
    bus(0, 8'h08, 32'h0);
    bus(0, 8'h20, 32'h0);
    for (p = 89; p <= 181; p += 92) begin
      bus(1, 8'h04, p);
      bus(0, 8'h04, 32'h5A);
      bus(0, 8'h08, 32'h4);
      bus(1, 8'h08, 32'h4);
    end
    bus(1, 8'h04, 32'hB4);
    bus(0, 8'h04, 32'hB4);
    p = 90 + $unsigned($random(seed)) % 91;
    bus(1, 8'h04, p);
    bus(0, 8'h04, p);
    bus(1, 8'h04, 32'h5A);
    bus(1, 8'h00, 32'h3);
    bus(1, 8'h00, 32'h7);
    bus(0, 8'h00, 32'h3);
    bus(0, 8'h08, 32'h4);
    bus(1, 8'h08, 32'h4);
    for (int i = 0; i < 6; i++) begin
      bus(1, 8'h4C, CW[i]);
      bus(0, 8'h4C, CR[i]);
      bus(0, 8'h08, CW[i] != CR[i] ? 32'h4 : 32'h0);
      bus(1, 8'h08, 32'h4);
    end
    // Every input option against every day-mode setting
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 3; s++) begin
        for (int o = 0; o < 4; o++) begin
          idx = $unsigned($random(seed)) % 16;
          bus(1, 8'h40 + 8'(4 * idx), o);
          bus(1, 8'h00, d + 2 * s);
          fire(idx, eff(o, d, s));
          clean();
        end
      end
    end
    // Detector and zone module restart, slow partner wake-up
    bus(1, 8'h00, 32'h0);
    wake <= 4'hA;
    for (int k = 0; k < 2; k++) begin
      bus(1, 8'h54, k ? 32'h81 : 32'h01);
      fire(5, 2'h1);
      chk("addr", 5, raddr);
      chk("zone", 1, zone);
      wait_obs(1, 1'b0, 200, c);
      chk_rng("retard", 19 * TK - 2, 20 * TK + 2, c);
      wait_obs(3, 1'b1, 200, c);
      chk_rng("restart", (k ? 9 : 2) * TK - 2, (k ? 10 : 3) * TK + 2, c);
      clean();
    end
    // Confirmation: network alarm, re-alarm, quiet return to standby
    bus(1, 8'h04, 32'h64);
    bus(1, 8'h5C, 32'h01);
    for (int k = 0; k < 3; k++) begin
      fire(7, 2'h1);
      smoke[7] <= 1'b0;
      wait_obs(1, 1'b0, 200, c);
      repeat (5 * TK) @(posedge clock);
      if (k == 0) net_alarm <= 1'b1;
      if (k == 1) smoke[7] <= 1'b1;
      if (k < 2) begin
        wait_obs(3, 1'b1, 4, c);
        chk_rng("realarm", 0, 2, c);
      end else begin
        wait_obs(2, 1'b0, 400, c);
        chk_rng("confirm", 74 * TK - 3, 76 * TK + 3, c);
        chk("standby", 0, alarm);
      end
      clean();
    end
    // Supervisory latching follows the panel bit, generic never latches
    bus(1, 8'h68, 32'h14);
    bus(1, 8'h6C, 32'h18);
    bus(1, 8'h70, 32'h04);
    for (int l = 0; l < 2; l++) begin
      bus(1, 8'h00, 8 * l);
      smoke[12:10] <= 3'h7;
      @(posedge clock);
      smoke[12:10] <= 3'h0;
      repeat (3) @(posedge clock);
      chk("pstat", 32'h1000 | (32'h400 * l), pstat);
      bus(0, 8'h0C, 32'h1000 | (32'h400 * l));
      clean();
      chk("pstat", 32'h0, pstat);
      bus(0, 8'h0C, 32'h0);
    end
    // Ten option cases, two restart runs and three confirmation runs started verification
    bus(0, 8'h10, 32'hF);
    bus(1, 8'h10, 32'h0);
    bus(0, 8'h10, 32'h0);
    repeat (3) @(posedge clock);
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    $display("mismatch run length expected end seen timeout");
    test_done();
  end
endmodule // adv_verifier_test
